// file: design/hsp_device.sv
module hsp_device #(
  parameter int MS_CYCLES = hsp_pkg::SAMPLE_CYCLES,
  parameter int STEP_CYCLES = 64
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link to host
  hsp_link_if.dev link,
  // analog front end
  input wire logic enAbove,
  input wire logic ovAbove,
  input wire logic senseOver4mv,
  input wire logic gateIsLow,
  input wire logic retryExhausted,
  input wire logic [15:0] tempCode,
  input wire logic [5:0] addrStraps,
  input wire logic porGood,
  input wire logic refPinLow,
  input wire logic refAbove2v4,
  // drive outputs
  output logic gateDriveOn,
  output logic diodeStepOn
);
  import hsp_pkg::*;

  initial begin
    if (MS_CYCLES < STEP_CYCLES + 2 || STEP_CYCLES < 1) begin
      $error("hsp_device: sample period too short for step pulse");
    end
  end

  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0] respSync;
    logic respSeen;
    logic [5:0] bitCnt;
    logic [FRAME_BITS-1:0] rxShift;
    logic [FRAME_BITS-1:0] rxWord;
    logic rxTgl;
    logic [RESP_BITS-1:0] txHold;
    logic [RESP_BITS-1:0] txShift;
    logic miso;
  } hsp_link_s;

  typedef struct packed {
    logic [2:0] rxSync;
    logic [1:0] enS;
    logic [1:0] ovS;
    logic [1:0] senseS;
    logic [1:0] gateLowS;
    logic [1:0] refLowS;
    logic [1:0] refHighS;
    logic [1:0] porS;
    logic [15:0] tempS0;
    logic [15:0] tempS1;
    logic lkRst;
    logic [1:0] lkAckS;
    logic [5:0] straps0;
    logic [5:0] straps1;
    logic enPrev;
    logic [31:0] msCnt;
    logic step;
    logic [15:0] temp;
    logic otWarn;
    logic otFault;
    logic [15:0] warnLim;
    logic [15:0] faultLim;
    logic [15:0] suppress;
    logic [7:0] onOff;
    logic shorted;
    logic latchedOff;
    logic addrValid;
    logic [6:0] busAddr;
    logic [RESP_BITS-1:0] resp;
    logic respTgl;
    logic gate;
    logic alert;
  } hsp_core_s;

  hsp_link_s lk_r, lk_nxt;
  hsp_core_s c_r, c_nxt;

  // link side: shift frames in, hand whole words to the core by toggle
  always_comb begin
    lk_nxt = lk_r;
    // core holds this request until the link clock has carried it over
    lk_nxt.rstSync = {lk_r.rstSync[0], c_r.lkRst};
    lk_nxt.respSync = {lk_r.respSync[0], c_r.respTgl};
    // response word changes with its toggle, so it is stable before the synced toggle arrives here
    if (lk_r.respSync[1] != lk_r.respSeen) begin
      lk_nxt.respSeen = lk_r.respSync[1];
      lk_nxt.txHold = c_r.resp;
    end
    if (!link.frameSel) begin
      lk_nxt.bitCnt = '0;
      // a just-posted answer goes out at once, else its first bit is stale
      lk_nxt.txShift = lk_nxt.txHold;
      lk_nxt.miso = lk_nxt.txHold[RESP_BITS-1];
    end else if (lk_r.bitCnt < 6'(FRAME_BITS)) begin
      lk_nxt.bitCnt = lk_r.bitCnt + 6'd1;
      lk_nxt.rxShift = {lk_r.rxShift[FRAME_BITS-2:0], link.hostToDev};
      lk_nxt.txShift = {lk_r.txShift[RESP_BITS-2:0], 1'b0};
      lk_nxt.miso = lk_r.txShift[RESP_BITS-2];
      if (lk_r.bitCnt == 6'(FRAME_BITS - 1)) begin
        lk_nxt.rxWord = {lk_r.rxShift[FRAME_BITS-2:0], link.hostToDev};
        lk_nxt.rxTgl = ~lk_r.rxTgl;
      end
    end
    if (lk_r.rstSync[1]) begin
      lk_nxt = '0;
      lk_nxt.rstSync = {lk_r.rstSync[0], c_r.lkRst};
    end
  end

  always_ff @(posedge link.linkClk) begin
    lk_r <= lk_nxt;
  end

  // a strap digit weighted by its place, kept in the address width
  function automatic logic [6:0] strapAddr(input logic [5:0] s);
    strapAddr = BUS_ADDR_BASE + 7'(s[1:0])
      + 7'(STRAP_RADIX) * 7'(s[3:2])
      + 7'(STRAP_RADIX * STRAP_RADIX) * 7'(s[5:4]);
  endfunction

  logic [7:0] rxCmd;
  logic [15:0] rxData;
  logic [15:0] sumWord;
  assign rxCmd = lk_r.rxWord[CMD_HI:CMD_LO];
  assign rxData = lk_r.rxWord[RESP_BITS-1:0];

  // core side: supervision, measurement pacing and command handling
  always_comb begin
    c_nxt = c_r;
    sumWord = '0;
    sumWord[SUM_SHORTED] = c_r.shorted;
    sumWord[SUM_LATCHED_OFF] = c_r.latchedOff;
    sumWord[SUM_OT_WARN] = c_r.otWarn;
    sumWord[SUM_OT_FAULT] = c_r.otFault;
    c_nxt.rxSync = {c_r.rxSync[1:0], lk_r.rxTgl};
    c_nxt.enS = {c_r.enS[0], enAbove};
    c_nxt.ovS = {c_r.ovS[0], ovAbove};
    c_nxt.senseS = {c_r.senseS[0], senseOver4mv};
    c_nxt.gateLowS = {c_r.gateLowS[0], gateIsLow};
    c_nxt.refLowS = {c_r.refLowS[0], refPinLow};
    c_nxt.refHighS = {c_r.refHighS[0], refAbove2v4};
    c_nxt.porS = {c_r.porS[0], porGood};
    c_nxt.tempS0 = tempCode;
    c_nxt.tempS1 = c_r.tempS0;
    // link side leaves reset only after its flops have reported back
    c_nxt.lkAckS = {c_r.lkAckS[0], lk_r.rstSync[1]};
    if (c_r.lkAckS[1]) begin
      c_nxt.lkRst = 1'b0;
    end
    c_nxt.straps0 = addrStraps;
    c_nxt.straps1 = c_r.straps0;
    c_nxt.enPrev = c_r.enS[1];

    // millisecond pacing of the diode current step
    if (c_r.msCnt >= 32'(MS_CYCLES - 1)) begin
      c_nxt.msCnt = '0;
    end else begin
      c_nxt.msCnt = c_r.msCnt + 32'd1;
    end
    c_nxt.step = (c_r.msCnt < 32'(STEP_CYCLES));
    // sample ends with the step; compare only then
    if (c_r.msCnt == 32'(STEP_CYCLES)) begin
      c_nxt.temp = c_r.tempS1;
      c_nxt.otWarn = c_r.tempS1 > c_r.warnLim;
      c_nxt.otFault = c_r.tempS1 > c_r.faultLim;
    end

    // re-arming by enable toggle; a new exhaust event wins
    if (c_r.enS[1] && !c_r.enPrev) begin
      c_nxt.latchedOff = 1'b0;
    end
    if (retryExhausted) begin
      c_nxt.latchedOff = 1'b1;
    end

    // host commands, only to our own captured address
    // frames are ignored until the link side is out of reset
    if (c_r.rxSync[2] != c_r.rxSync[1] && c_r.addrValid
        && !c_r.lkRst && !c_r.lkAckS[1]
        && lk_r.rxWord[ADR_HI:ADR_LO] == c_r.busAddr) begin
      if (lk_r.rxWord[RD_BIT]) begin
        c_nxt.respTgl = ~c_r.respTgl;
        case (rxCmd)
          CMD_OUTPUT_ON_OFF: c_nxt.resp = {8'h00, c_r.onOff};
          CMD_OT_FAULT_LIM: c_nxt.resp = c_r.faultLim;
          CMD_OT_WARN_LIM: c_nxt.resp = c_r.warnLim;
          CMD_VENDOR_STATUS: begin
            c_nxt.resp = '0;
            c_nxt.resp[VSTAT_SHORTED] = c_r.shorted;
          end
          CMD_TEMP_READ: c_nxt.resp = c_r.temp;
          CMD_NOTIFY_SUPPRESS: c_nxt.resp = c_r.suppress;
          CMD_FAULT_SUMMARY: c_nxt.resp = sumWord;
          default: c_nxt.resp = READ_MISS_VALUE;
        endcase
      end else begin
        case (rxCmd)
          CMD_OUTPUT_ON_OFF: begin
            // only the two defined values change the output state
            if (rxData[7:0] == OUTPUT_ON || rxData[7:0] == OUTPUT_OFF) begin
              c_nxt.onOff = rxData[7:0];
            end
          end
          CMD_OT_FAULT_LIM: c_nxt.faultLim = rxData;
          CMD_OT_WARN_LIM: c_nxt.warnLim = rxData;
          CMD_NOTIFY_SUPPRESS: c_nxt.suppress = rxData;
          CMD_CLEAR_FLAGS: c_nxt.shorted = 1'b0;
          default: c_nxt.shorted = c_r.shorted;
        endcase
      end
    end

    // shorted switch: current flows while the gate is or should be off
    if (c_r.senseS[1] && (c_r.gateLowS[1] || !c_r.gate)) begin
      c_nxt.shorted = 1'b1;
    end

    // gate drive; the pins here only gate it and never touch onOff or the limits
    c_nxt.gate = c_r.onOff[OUTPUT_ON_BIT] && c_r.enS[1]
      && !c_r.ovS[1] && !c_r.otFault && !c_r.latchedOff;
    c_nxt.alert = (c_r.shorted && !c_r.suppress[SUM_SHORTED])
      || (c_r.otWarn && !c_r.suppress[SUM_OT_WARN]);

    // address capture after POR and a charged reference pin
    if (!c_r.addrValid && c_r.porS[1] && c_r.refHighS[1]) begin
      c_nxt.addrValid = 1'b1;
      c_nxt.busAddr = strapAddr(c_r.straps1);
    end

    // reference pin low acts as reset and keeps capture pending
    if (reset || c_r.refLowS[1]) begin
      c_nxt = '0;
      c_nxt.lkAckS = {c_r.lkAckS[0], lk_r.rstSync[1]};
      c_nxt.lkRst = c_r.lkRst && !c_r.lkAckS[1];
      c_nxt.rxSync = c_r.rxSync;
      c_nxt.respTgl = c_r.respTgl;
      c_nxt.warnLim = OT_WARN_DEFAULT;
      c_nxt.faultLim = OT_FAULT_DEFAULT;
      c_nxt.suppress = SUPPRESS_DEFAULT;
      c_nxt.onOff = OUTPUT_ON;
      if (reset) begin
        c_nxt.rxSync = '0;
        c_nxt.respTgl = 1'b0;
        c_nxt.lkRst = 1'b1;
      end
      c_nxt.refLowS = reset ? 2'b00 : c_r.refLowS;
      c_nxt.refLowS[1] = reset ? 1'b0 : c_r.refLowS[0];
      c_nxt.refLowS[0] = reset ? 1'b0 : refPinLow;
    end
  end

  always_ff @(posedge core_clk) begin
    c_r <= c_nxt;
  end

  // every pin driven straight from a flip-flop, except alertOut, which is tied low
  assign gateDriveOn = c_r.gate;
  assign diodeStepOn = c_r.step;
  assign link.devToHost = lk_r.miso;
  assign link.alertOut = 1'b0;
  assign link.alertOe = c_r.alert;
endmodule

// file: design/hsp_pkg.sv
package hsp_pkg;
  // link frame: read flag, 7-bit address, command, 16-bit data
  localparam int FRAME_BITS = 32;
  localparam int RESP_BITS = 16;
  localparam int RD_BIT = 31;
  localparam int ADR_HI = 30;
  localparam int ADR_LO = 24;
  localparam int CMD_HI = 23;
  localparam int CMD_LO = 16;
  // command codes of the device
  localparam logic [7:0] CMD_OUTPUT_ON_OFF = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT_LIM = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN_LIM = 8'h51;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_TEMP_READ = 8'h8d;
  localparam logic [7:0] CMD_NOTIFY_SUPPRESS = 8'hd8;
  localparam logic [7:0] CMD_FAULT_SUMMARY = 8'he1;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'hf0;
  // output on/off values
  localparam logic [7:0] OUTPUT_ON = 8'h80;
  localparam logic [7:0] OUTPUT_OFF = 8'h00;
  localparam int OUTPUT_ON_BIT = 7;
  // reset values, temperature in whole degrees
  localparam logic [15:0] OT_WARN_DEFAULT = 16'h007d;
  localparam logic [15:0] OT_FAULT_DEFAULT = 16'h0096;
  localparam logic [15:0] SUPPRESS_DEFAULT = 16'h0000;
  localparam logic [15:0] READ_MISS_VALUE = 16'h0000;
  // flag positions; SUM_* shared by summary word and suppress mask, VSTAT_SHORTED in vendor status
  localparam int SUM_SHORTED = 0;
  localparam int SUM_LATCHED_OFF = 1;
  localparam int SUM_OT_WARN = 2;
  localparam int SUM_OT_FAULT = 3;
  localparam int VSTAT_SHORTED = 7;
  // address strap codes per pin: 0 ground, 1 open, 2 tied high
  localparam logic [6:0] BUS_ADDR_BASE = 7'h40;
  localparam int STRAP_RADIX = 3;
  // timing
  localparam int CORE_PERIOD_NS = 4;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CORE_PERIOD_NS;
  localparam int LINK_HALF_CYCLES = 6;
  localparam int GAP_FALLS = 2;
  // host register map, byte addresses
  localparam logic [7:0] HREG_FRAME = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam int HST_BUSY = 30;
  localparam int HST_ALERT = 31;
endpackage

// file: design/hsp_link_if.sv
interface hsp_link_if;
  logic linkClk;
  logic frameSel;
  logic hostToDev;
  logic devToHost;
  logic alertOut;
  logic alertOe;
  wire alertN;
  // open-drain alert line with pull-up
  assign alertN = alertOe ? alertOut : 1'b1;
  modport dev (input linkClk, input frameSel, input hostToDev,
    output devToHost, output alertOut, output alertOe);
  modport host (output linkClk, output frameSel, output hostToDev,
    input devToHost, input alertN);
endinterface

// file: design/hsp_host.sv
module hsp_host #(
  parameter int HALF_CYCLES = hsp_pkg::LINK_HALF_CYCLES
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // link to device
  hsp_link_if.host link
);
  import hsp_pkg::*;

  initial begin
    if (HALF_CYCLES < 2 || HALF_CYCLES > 255) begin
      $error("hsp_host: HALF_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b10
  } hsp_state_e;

  typedef struct packed {
    hsp_state_e st;
    logic [7:0] div;
    logic clk;
    logic sel;
    logic mosi;
    logic pending;
    logic [5:0] bits;
    logic [FRAME_BITS-1:0] txWord;
    logic [RESP_BITS-1:0] rxWord;
    logic [1:0] alertS;
    logic ack;
    logic [31:0] datR;
  } hsp_host_s;

  hsp_host_s s_r, s_nxt;
  logic edgeNow;
  logic fallNow;
  logic riseNow;
  logic busy;

  always_comb begin
    s_nxt = s_r;
    edgeNow = (s_r.div == 8'(HALF_CYCLES - 1));
    fallNow = edgeNow && s_r.clk;
    riseNow = edgeNow && !s_r.clk;
    busy = s_r.pending || s_r.st != ST_IDLE;
    // free-running divided link clock
    s_nxt.div = edgeNow ? 8'h00 : s_r.div + 8'h01;
    if (edgeNow) begin
      s_nxt.clk = ~s_r.clk;
    end
    s_nxt.alertS = {s_r.alertS[0], ~link.alertN};

    // wishbone: answer one cycle after the request, drop next cycle
    s_nxt.ack = wbCyc && wbStb && !s_r.ack;
    if (wbCyc && wbStb && !s_r.ack) begin
      s_nxt.datR = 32'h0000_0000;
      if (wbWe && wbAdr == HREG_FRAME && wbSel == 4'hf && !busy) begin
        s_nxt.txWord = wbDatW;
        s_nxt.pending = 1'b1;
      end
      if (!wbWe && wbAdr == HREG_STATUS) begin
        s_nxt.datR = {s_r.alertS[1], busy, 14'h0000, s_r.rxWord};
      end
    end

    // data changes on falling edges; the device samples on rising
    case (s_r.st)
      ST_IDLE: begin
        if (fallNow && s_r.pending) begin
          s_nxt.pending = 1'b0;
          s_nxt.sel = 1'b1;
          s_nxt.mosi = s_r.txWord[FRAME_BITS-1];
          s_nxt.txWord = {s_r.txWord[FRAME_BITS-2:0], 1'b0};
          s_nxt.bits = '0;
          s_nxt.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (riseNow && s_r.bits < 6'(RESP_BITS)) begin
          s_nxt.rxWord = {s_r.rxWord[RESP_BITS-2:0], link.devToHost};
        end
        if (fallNow) begin
          s_nxt.bits = s_r.bits + 6'd1;
          s_nxt.mosi = s_r.txWord[FRAME_BITS-1];
          s_nxt.txWord = {s_r.txWord[FRAME_BITS-2:0], 1'b0};
          if (s_r.bits == 6'(FRAME_BITS - 1)) begin
            s_nxt.sel = 1'b0;
            s_nxt.mosi = 1'b0;
            s_nxt.bits = '0;
            s_nxt.st = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        // idle link clocks let the device post its answer
        if (fallNow) begin
          s_nxt.bits = s_r.bits + 6'd1;
          if (s_r.bits == 6'(GAP_FALLS - 1)) begin
            s_nxt.st = ST_IDLE;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (reset) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  assign wbAck = s_r.ack;
  assign wbDatR = s_r.datR;
  assign link.linkClk = s_r.clk;
  assign link.frameSel = s_r.sel;
  assign link.hostToDev = s_r.mosi;
endmodule

// file: tb/hsp_props.sv
module hsp_props #(
  parameter int MS_CYCLES = 200
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link signals
  input wire logic linkClk,
  input wire logic frameSel,
  input wire logic alertOut,
  input wire logic alertOe,
  input wire logic alertN,
  // device pins
  input wire logic enAbove,
  input wire logic ovAbove,
  input wire logic gateDriveOn,
  input wire logic diodeStepOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] bitCnt_r;
  logic [15:0] gapCnt_r;
  logic stepPrev_r;
  // bits of a frame, counted on the device's sampling edge
  always_ff @(posedge linkClk) begin
    if (reset) bitCnt_r <= 6'h00;
    else bitCnt_r <= frameSel ? bitCnt_r + 6'h01 : 6'h00;
  end
  // cycles since the last current step began; zero until one was seen
  always_ff @(posedge core_clk) begin
    stepPrev_r <= diodeStepOn;
    if (reset) gapCnt_r <= 16'h0000;
    else if (diodeStepOn && !stepPrev_r) gapCnt_r <= 16'h0001;
    else if (gapCnt_r != 16'h0000) gapCnt_r <= gapCnt_r + 16'h0001;
  end
  chk_alert_pulls_low:
    assert property (@(posedge core_clk) disable iff (reset)
      alertOe |-> !alertOut && !alertN) else $error("alert not low");
  chk_alert_released:
    assert property (@(posedge core_clk) disable iff (reset)
      !alertOe |-> alertN) else $error("alert held without drive");
  chk_gate_enable:
    assert property (@(posedge core_clk) disable iff (reset)
      !enAbove [*5] |-> !gateDriveOn) else $error("gate on, enable low");
  chk_gate_overvolt:
    assert property (@(posedge core_clk) disable iff (reset)
      ovAbove [*5] |-> !gateDriveOn) else $error("gate on, overvoltage");
  chk_step_period:
    assert property (@(posedge core_clk) disable iff (reset)
      (diodeStepOn && !stepPrev_r && gapCnt_r != 16'h0000)
      |-> int'(gapCnt_r) == MS_CYCLES) else $error("sample period wrong");
  chk_frame_length:
    assert property (@(posedge linkClk) disable iff (reset)
      (!frameSel && bitCnt_r != 6'h00) |-> bitCnt_r == 6'd32)
      else $error("frame not 32 bits");
  chk_frame_gap:
    assert property (@(posedge linkClk) disable iff (reset)
      $fell(frameSel) |=> !frameSel) else $error("no idle gap");
  chk_alert_settles:
    assert property (@(posedge core_clk) disable iff (reset)
      $rose(alertOe) |-> alertOe [*2]) else $error("alert glitch");
endmodule

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hsp_pkg::*;
  localparam int MS = 200;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR, rdat;
  logic enAbove = 1'b1, ovAbove = 1'b0, senseOver4mv = 1'b0;
  logic retryExhausted = 1'b0, refPinLow = 1'b0, refAbove2v4 = 1'b1;
  logic [15:0] tempCode = 16'h0000;
  logic [5:0] addrStraps = 6'h00;
  logic gateDriveOn, diodeStepOn;
  logic [6:0] devAdr;
  int failures = 0;
  int n_checks = 0;
  // behavioural model of the device state
  int mT, mWarn, mFault, mSup, mOn, mShort, mLatch;

  hsp_link_if lnk ();
  hsp_device #(.MS_CYCLES(MS), .STEP_CYCLES(8)) hsp_device_inst (
    .core_clk(core_clk), .reset(reset), .link(lnk.dev),
    .enAbove(enAbove), .ovAbove(ovAbove), .senseOver4mv(senseOver4mv),
    .gateIsLow(!gateDriveOn), .retryExhausted(retryExhausted),
    .tempCode(tempCode), .addrStraps(addrStraps), .porGood(1'b1),
    .refPinLow(refPinLow), .refAbove2v4(refAbove2v4),
    .gateDriveOn(gateDriveOn), .diodeStepOn(diodeStepOn));
  hsp_host hsp_host_inst (
    .core_clk(core_clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .link(lnk.host));
  // the reference pin resets the device core, so the checker restarts too
  hsp_props #(.MS_CYCLES(MS)) hsp_props_inst (
    .core_clk(core_clk), .reset(reset || refPinLow),
    .linkClk(lnk.linkClk), .frameSel(lnk.frameSel),
    .alertOut(lnk.alertOut), .alertOe(lnk.alertOe), .alertN(lnk.alertN),
    .enAbove(enAbove), .ovAbove(ovAbove), .gateDriveOn(gateDriveOn),
    .diodeStepOn(diodeStepOn));

  always #2 core_clk = ~core_clk;

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; the wait for ack is bounded
  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 50) begin
      failures++;
      conclude();
    end
  endtask

  // send one frame and poll status until the link is idle again
  task automatic frame(input logic rd, input logic [7:0] cmd,
      input logic [15:0] d);
    int n;
    wb(1'b1, HREG_FRAME, {rd, devAdr, cmd, d});
    n = 0;
    do begin
      wb(1'b0, HREG_STATUS, 32'h0);
      n++;
    end while (rdat[HST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      failures++;
      conclude();
    end
  endtask

  // a read answers in the following frame
  task automatic devRead(input logic [7:0] cmd);
    frame(1'b1, cmd, 16'h0000);
    frame(1'b1, cmd, 16'h0000);
  endtask

  task automatic straps();
    int a0, a1, a2;
    a0 = $urandom_range(2, 0);
    a1 = $urandom_range(2, 0);
    a2 = $urandom_range(2, 0);
    addrStraps <= {a2[1:0], a1[1:0], a0[1:0]};
    devAdr = 7'(7'h40 + a0 + 3 * a1 + 9 * a2);
  endtask

  task automatic modelReset();
    mWarn = 125;
    mFault = 150;
    mSup = 0;
    mOn = 1;
    mShort = 0;
    mLatch = 0;
  endtask

  task automatic restart();
    frame(1'b0, CMD_OUTPUT_ON_OFF, 16'h0000);
    frame(1'b0, CMD_OUTPUT_ON_OFF, 16'h0080);
    mOn = 1;
  endtask

  // a short burst of sense current, seen through the device's sync
  task automatic pulseSense();
    @(posedge core_clk);
    senseOver4mv <= 1'b1;
    repeat (3) @(posedge core_clk);
    senseOver4mv <= 1'b0;
  endtask

  // let two samples pass, then compare pins and registers with the model
  task automatic verify();
    logic [3:0] s;
    repeat (2 * MS + 20) @(posedge core_clk);
    s = {mT > mFault, mT > mWarn, mLatch[0], mShort[0]};
    check(gateDriveOn, mOn && enAbove && !ovAbove && !s[3] && !s[1]);
    check(lnk.alertN, !((s[2] && !mSup[2]) || (s[0] && !mSup[0])));
    devRead(CMD_TEMP_READ);
    check(rdat[15:0], mT);
    devRead(CMD_FAULT_SUMMARY);
    check(rdat[3:0], s);
    devRead(CMD_VENDOR_STATUS);
    check(rdat[VSTAT_SHORTED], mShort);
  endtask

  initial begin
    logic [7:0] cmds [4];
    int vals [4];
    int temps [4];
    cmds = '{CMD_OT_FAULT_LIM, CMD_OT_WARN_LIM, CMD_NOTIFY_SUPPRESS,
      CMD_OUTPUT_ON_OFF};
    vals = '{150, 125, 0, 128};
    temps = '{125, 126, 150, 151};
    void'($urandom(32'h0b9f));
    straps();
    mT = $urandom_range(120, 20);
    tempCode <= mT[15:0];
    modelReset();
    // reset is short; the device carries it to its link side itself
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    check(rdat, 32'h0);
    // frames wait for the link side reset and the address capture
    repeat (100) @(posedge core_clk);
    foreach (cmds[i]) begin
      devRead(cmds[i]);
      check(rdat[15:0], vals[i]);
    end
    verify();
    $display("test defaults done");
    foreach (temps[i]) begin
      mT = temps[i];
      tempCode <= mT[15:0];
      verify();
      restart();
    end
    mT = $urandom_range(120, 20);
    tempCode <= mT[15:0];
    mWarn = mT - 1;
    frame(1'b0, CMD_OT_WARN_LIM, mWarn[15:0]);
    verify();
    mFault = mT - 1;
    frame(1'b0, CMD_OT_FAULT_LIM, mFault[15:0]);
    verify();
    mWarn = 100;
    mFault = 150;
    frame(1'b0, CMD_OT_WARN_LIM, 16'd100);
    frame(1'b0, CMD_OT_FAULT_LIM, 16'd150);
    restart();
    verify();
    $display("test thresholds done");
    // sense current while the gate is on is normal load current
    pulseSense();
    devRead(CMD_VENDOR_STATUS);
    check(rdat[VSTAT_SHORTED], 1'b0);
    frame(1'b0, CMD_OUTPUT_ON_OFF, 16'h0000);
    mOn = 0;
    pulseSense();
    mShort = 1;
    verify();
    frame(1'b0, CMD_NOTIFY_SUPPRESS, 16'h0005);
    mSup = 5;
    verify();
    frame(1'b0, CMD_CLEAR_FLAGS, 16'h0000);
    frame(1'b0, CMD_NOTIFY_SUPPRESS, 16'h0000);
    frame(1'b0, CMD_OUTPUT_ON_OFF, 16'h0080);
    frame(1'b0, CMD_OUTPUT_ON_OFF, 16'h0055);
    mShort = 0;
    mSup = 0;
    mOn = 1;
    verify();
    $display("test shorted switch done");
    enAbove <= 1'b0;
    verify();
    enAbove <= 1'b1;
    repeat (10) @(posedge core_clk);
    retryExhausted <= 1'b1;
    @(posedge core_clk);
    retryExhausted <= 1'b0;
    mLatch = 1;
    verify();
    ovAbove <= 1'b1;
    enAbove <= 1'b0;
    repeat (10) @(posedge core_clk);
    enAbove <= 1'b1;
    mLatch = 0;
    verify();
    ovAbove <= 1'b0;
    verify();
    devRead(CMD_OT_WARN_LIM);
    check(rdat[15:0], 100);
    $display("test enable pins done");
    refPinLow <= 1'b1;
    refAbove2v4 <= 1'b0;
    straps();
    repeat (20) @(posedge core_clk);
    refPinLow <= 1'b0;
    modelReset();
    frame(1'b0, CMD_OT_WARN_LIM, 16'd60);
    refAbove2v4 <= 1'b1;
    repeat (10) @(posedge core_clk);
    devRead(CMD_OT_WARN_LIM);
    check(rdat[15:0], 125);
    verify();
    $display("test reference pin done");
    conclude();
  end
endmodule
